//--- core/blo_defines.svh
`ifndef BLO_DEFINES_SVH
`define BLO_DEFINES_SVH
`define BLO_CLK_HZ 20000000
`define BLO_TICK_MS 100
`define BLO_CTL_DB_MS 20
`define BLO_SNS_DB_CYCLES 2
`define BLO_RESET_HOLD_MS 2000
`define BLO_RESET_LONG_MS 3000
`define BLO_DETECT_ERR_MS 5000
`define BLO_FALSE_FLAME_MS 5000
`define BLO_MAIN_FALSE_MS 5000
`define BLO_MAIN_EXT_WAIT_MS 1000
`define BLO_CHECK_TICKS 30
`define BLO_PILOT_TICKS 50
`define BLO_PILOT_ONLY_TICKS 50
`define BLO_MAIN_TICKS 50
`define BLO_VALVE_TICKS 10
`define BLO_TICKS_W 8
`define BLO_ZONE_W 8
`define BLO_ERR_W 5
`define BLO_ERR_IGN 0
`define BLO_ERR_FLAME 1
`define BLO_ERR_FALSE 2
`define BLO_ERR_DETECT 3
`define BLO_ERR_VALVE 4
`define BLO_CTL_W 2
`define BLO_C_RST 0
`define BLO_C_START 1
`define BLO_SNS_W 8
`define BLO_S_ILK 0
`define BLO_S_FLAME 1
`define BLO_S_MAIN 2
`define BLO_S_SHUT 3
`define BLO_S_PCA 4
`define BLO_S_PCB 5
`define BLO_S_MCA 6
`define BLO_S_MCB 7
`endif

//--- core/blo_pkg.sv
`include "blo_defines.svh"
package blo_pkg;
  typedef enum logic [3:0] {
    st_standby, st_check, st_false, st_pilot_trial, st_pilot_only,
    st_main_wait, st_main_trial, st_run, st_lockout, st_hold
  } blo_state_t;
  typedef logic [`BLO_TICKS_W-1:0] blo_ticks_t;
  typedef logic [`BLO_ERR_W-1:0] blo_err_t;
  typedef logic [`BLO_ZONE_W-1:0] blo_zone_t;
endpackage

//--- core/blo_input_filter.sv
module blo_input_filter #(
  parameter int WIDTH = 2,
  parameter int DB_CYCLES = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);
  import blo_pkg::*;
  localparam int CW = $clog2(DB_CYCLES + 1);
  if (WIDTH < 1 || DB_CYCLES < 1) begin : g_bad
    $error("blo_input_filter: bad WIDTH or DB_CYCLES");
  end
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
  logic [WIDTH-1:0] nxt_lvl;
  logic [CW-1:0] cnt_ff [WIDTH];
  logic [CW-1:0] nxt_cnt [WIDTH];
  // A change is taken only after stage two and three agree for the whole window
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_cnt[i] = '0;
      nxt_lvl[i] = lvl_ff[i];
      if (s2_ff[i] == s3_ff[i] && s3_ff[i] != lvl_ff[i]) begin
        if (cnt_ff[i] == CW'(DB_CYCLES - 1)) begin
          nxt_lvl[i] = s3_ff[i];
        end else begin
          nxt_cnt[i] = cnt_ff[i] + CW'(1);
        end
      end
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
      for (int i = 0; i < WIDTH; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      s1_ff <= i_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
      fall_ff <= ~nxt_lvl & lvl_ff;
      cnt_ff <= nxt_cnt;
    end
  end
  assign o_level = lvl_ff;
  assign o_rise = rise_ff;
  assign o_fall = fall_ff;
endmodule

//--- core/blo_sequencer.sv
`include "blo_defines.svh"
// Overview of operation
// - Hot mode: flame loss raises warning, run continues; mode exit, or a reset counted during lockout, clears.
// - After reset with start on: LED blinks, alarms stay; off when start drops with interlock normal.
// - Reset contact already closed when error occurs is ignored.
// - Each reset clears one pending error; repeat until all are gone.
// - Linked interlock cancellation also cancels this lockout.
// - Legacy interlock reset that leaves errors raises hold time to three seconds.
// - Reset with start on and lockouts at threshold: zones standby until start off.
// - Below threshold and nothing combusting: zone prepurge after reset.
// - No flame by end of pilot or main trial: ignition failure lockout.
// - Ignition lockout: alarms on, valves shut, start forced off internally.
// - Lockout alarm clears only on reset with starts off and interlock normal.
// - Flame loss in pilot-only or run: valves shut, flame failure lockout.
// - Sensor current with shutter closed five seconds: detection error, not flame failure.
// - Standby flame ignored; flame in start check holds; restart when gone.
// - False flame standby over five seconds locks out; alarm if configured.
// - Main flame before main trial for five seconds locks out.
// - Main flame gone: wait one second, then main trial; return restarts check.
// - No valve lockout in standby; start check finds switch open: lockout.
// - Pilot valve open and its switch reads closed for period: lockout.
// - Main valve open: lockout only when both confirm inputs read closed.
module blo_sequencer #(
  parameter int TICK_CYCLES = `BLO_CLK_HZ / 1000 * `BLO_TICK_MS,
  parameter int CTL_DB_CYCLES = `BLO_CLK_HZ / 1000 * `BLO_CTL_DB_MS,
  parameter int SNS_DB_CYCLES = `BLO_SNS_DB_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_contact,
  input wire logic i_start,
  input wire logic i_interlock_ok,
  input wire logic i_flame_sense,
  input wire logic i_main_flame_sense,
  input wire logic i_shutter_closed,
  input wire logic i_pilot_closed_confirm_a,
  input wire logic i_pilot_closed_confirm_b,
  input wire logic i_main_closed_confirm_a,
  input wire logic i_main_closed_confirm_b,
  input wire logic i_hot_mode,
  input wire logic i_alarm_configured,
  input wire logic i_link_connected,
  input wire logic i_link_reset,
  input wire logic i_link_legacy,
  input wire blo_pkg::blo_zone_t i_zone_locked_count,
  input wire blo_pkg::blo_zone_t i_zone_threshold,
  input wire logic i_zone_combusting,
  output logic o_igniter_output,
  output logic o_pilot_valve_output,
  output logic o_main_valve_output,
  output logic o_lockout_alarm_output,
  output logic o_ignition_failure_alarm,
  output logic o_flame_failure_alarm,
  output logic o_false_flame_alarm,
  output logic o_detect_error_alarm,
  output logic o_valve_error_alarm,
  output logic o_hot_mode_flame_loss_warning,
  output logic o_led_blink,
  output logic o_monitor_output,
  output logic o_error_display,
  output logic o_zone_standby,
  output logic o_zone_prepurge_req
);
  import blo_pkg::*;
  localparam int TCW = $clog2(TICK_CYCLES);
  // Least times round up to whole ticks
  localparam blo_ticks_t RESET_HOLD_T = blo_ticks_t'((`BLO_RESET_HOLD_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t RESET_LONG_T = blo_ticks_t'((`BLO_RESET_LONG_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t DET_T = blo_ticks_t'((`BLO_DETECT_ERR_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t FALSE_T = blo_ticks_t'((`BLO_FALSE_FLAME_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t MAINF_T = blo_ticks_t'((`BLO_MAIN_FALSE_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t EXT_T = blo_ticks_t'((`BLO_MAIN_EXT_WAIT_MS + `BLO_TICK_MS - 1) / `BLO_TICK_MS);
  localparam blo_ticks_t CHECK_T = blo_ticks_t'(`BLO_CHECK_TICKS);
  localparam blo_ticks_t PILOT_T = blo_ticks_t'(`BLO_PILOT_TICKS);
  localparam blo_ticks_t PONLY_T = blo_ticks_t'(`BLO_PILOT_ONLY_TICKS);
  localparam blo_ticks_t MAIN_T = blo_ticks_t'(`BLO_MAIN_TICKS);
  localparam blo_ticks_t VALVE_T = blo_ticks_t'(`BLO_VALVE_TICKS);
  if (TICK_CYCLES < 2 || CTL_DB_CYCLES < 1 || SNS_DB_CYCLES < 1) begin : g_bad
    $error("blo_sequencer: bad cycle parameters");
  end

  function automatic blo_ticks_t tinc(input blo_ticks_t v, input logic en);
    return (en && v != '1) ? v + blo_ticks_t'(1) : v;
  endfunction
  function automatic blo_err_t clr_lowest(input blo_err_t e);
    return e & (e - blo_err_t'(1));
  endfunction
  function automatic logic valve_on(input blo_state_t s);
    return s inside {st_pilot_trial, st_pilot_only, st_main_wait, st_main_trial, st_run};
  endfunction

  logic [`BLO_CTL_W-1:0] c_lvl, c_rise, c_fall;
  logic [`BLO_SNS_W-1:0] s_lvl;
  blo_input_filter #(.WIDTH(`BLO_CTL_W), .DB_CYCLES(CTL_DB_CYCLES)) u_ctl_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_raw({i_start, i_reset_contact}),
    .o_level(c_lvl),
    .o_rise(c_rise),
    .o_fall(c_fall)
  );
  blo_input_filter #(.WIDTH(`BLO_SNS_W), .DB_CYCLES(SNS_DB_CYCLES)) u_sns_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_raw({i_main_closed_confirm_b, i_main_closed_confirm_a, i_pilot_closed_confirm_b,
            i_pilot_closed_confirm_a, i_shutter_closed, i_main_flame_sense, i_flame_sense, i_interlock_ok}),
    .o_level(s_lvl),
    .o_rise(),
    .o_fall()
  );
  wire rst_lvl = c_lvl[`BLO_C_RST];
  wire start = c_lvl[`BLO_C_START];
  wire ilk = s_lvl[`BLO_S_ILK];
  wire flame = s_lvl[`BLO_S_FLAME];
  wire main_fl = s_lvl[`BLO_S_MAIN];

  // Common timebase
  logic [TCW-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  always_comb begin
    nxt_tick_cnt = tick_cnt_ff + TCW'(1);
    nxt_tick = 1'b0;
    if (tick_cnt_ff == TCW'(TICK_CYCLES - 1)) begin
      nxt_tick_cnt = '0;
      nxt_tick = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  blo_state_t state_ff, nxt_state;
  blo_ticks_t st_t_ff, nxt_st_t, aux_t_ff, nxt_aux_t, det_t_ff, nxt_det_t, vlv_t_ff, nxt_vlv_t;
  blo_ticks_t rst_t_ff, nxt_rst_t;
  blo_err_t err_ff, nxt_err, alarm_ff, nxt_alarm, lock_bit;
  logic lockout_ff, nxt_lockout, armed_ff, nxt_armed, rst_valid_ff, nxt_rst_valid;
  logic long_ff, nxt_long, warn_ff, nxt_warn, zsb_ff, nxt_zsb, zpp_ff, nxt_zpp;
  logic [4:0] out_ff, nxt_out;
  logic clr_st, release_all, det_fault, vlv_fault, flame_lost, vlv_abn, in_run;
  logic stale_ff, nxt_stale;

  // Reset counts only if pressed after the lockout began, and only when released
  wire qual_reset = c_fall[`BLO_C_RST] && rst_valid_ff &&
                    rst_t_ff >= (long_ff ? RESET_LONG_T : RESET_HOLD_T);
  wire link_cancel = i_link_connected && i_link_reset && state_ff == st_lockout;
  wire cancel = qual_reset || link_cancel;

  always_comb begin
    nxt_state = state_ff;
    nxt_err = err_ff;
    nxt_alarm = alarm_ff;
    nxt_lockout = lockout_ff;
    nxt_armed = armed_ff;
    nxt_long = long_ff;
    nxt_warn = warn_ff;
    nxt_zsb = zsb_ff;
    nxt_zpp = 1'b0;
    nxt_aux_t = aux_t_ff;
    lock_bit = '0;
    clr_st = 1'b0;
    release_all = 1'b0;
    in_run = state_ff inside {st_pilot_only, st_main_wait, st_main_trial, st_run};
    nxt_rst_valid = rst_valid_ff;
    nxt_rst_t = tinc(rst_t_ff, rst_lvl && tick_ff);
    if (c_rise[`BLO_C_RST]) begin
      nxt_rst_valid = lockout_ff;
      nxt_rst_t = '0;
    end
    if (c_fall[`BLO_C_RST]) begin
      nxt_rst_valid = 1'b0;
    end
    if (i_link_legacy && link_cancel && clr_lowest(err_ff) != '0) begin
      nxt_long = 1'b1;
    end
    if (!start) begin
      nxt_armed = 1'b1;
      nxt_zsb = 1'b0;
    end
    // Faults checked outside the state case; detection error masks flame failure
    nxt_det_t = '0;
    if ((valve_on(state_ff) || state_ff inside {st_check, st_false}) && s_lvl[`BLO_S_SHUT] && flame) begin
      nxt_det_t = tinc(det_t_ff, tick_ff);
    end
    det_fault = det_t_ff >= DET_T;
    vlv_abn = valve_on(state_ff) && (s_lvl[`BLO_S_PCA] || s_lvl[`BLO_S_PCB] ||
              (state_ff inside {st_main_trial, st_run} && s_lvl[`BLO_S_MCA] && s_lvl[`BLO_S_MCB]));
    nxt_vlv_t = vlv_abn ? tinc(vlv_t_ff, tick_ff) : '0;
    vlv_fault = vlv_t_ff >= VALVE_T;
    flame_lost = in_run && (!flame || (state_ff == st_run && !main_fl));
    case (state_ff)
      st_standby: begin
        if (start && armed_ff) begin
          nxt_state = st_check;
        end
      end
      st_check: begin
        if (!start) begin
          nxt_state = st_standby;
        end else if (flame) begin
          nxt_state = st_false;
        end else if (st_t_ff >= CHECK_T) begin
          if (!(&s_lvl[`BLO_S_MCB:`BLO_S_PCA])) begin
            lock_bit[`BLO_ERR_VALVE] = 1'b1;
          end else begin
            nxt_state = st_pilot_trial;
          end
        end
      end
      st_false: begin
        if (!start) begin
          nxt_state = st_standby;
        end else if (!flame) begin
          nxt_state = st_check;
        end else if (st_t_ff >= FALSE_T) begin
          lock_bit[`BLO_ERR_FALSE] = 1'b1;
        end
      end
      st_pilot_trial: begin
        if (st_t_ff >= PILOT_T) begin
          if (flame) begin
            nxt_state = st_pilot_only;
          end else begin
            lock_bit[`BLO_ERR_IGN] = 1'b1;
          end
        end
      end
      st_pilot_only: begin
        // Main flame here is not an error until the main trial is due
        if (st_t_ff >= PONLY_T) begin
          nxt_state = main_fl ? st_main_wait : st_main_trial;
          nxt_aux_t = '0;
        end
      end
      st_main_wait: begin
        if (main_fl) begin
          nxt_aux_t = '0;
          if (st_t_ff >= MAINF_T) begin
            lock_bit[`BLO_ERR_FALSE] = 1'b1;
          end
        end else begin
          clr_st = 1'b1;
          nxt_aux_t = tinc(aux_t_ff, tick_ff);
          if (aux_t_ff >= EXT_T) begin
            nxt_state = st_main_trial;
          end
        end
      end
      st_main_trial: begin
        if (st_t_ff >= MAIN_T) begin
          if (main_fl) begin
            nxt_state = st_run;
          end else begin
            lock_bit[`BLO_ERR_IGN] = 1'b1;
          end
        end
      end
      st_run: begin
      end
      st_lockout: begin
        if (cancel) begin
          nxt_err = clr_lowest(err_ff);
          if (nxt_err == '0) begin
            if (!start && ilk) begin
              release_all = 1'b1;
            end else begin
              nxt_state = st_hold;
            end
            if (start && i_zone_locked_count >= i_zone_threshold) begin
              nxt_zsb = 1'b1;
            end else if (start && !i_zone_combusting) begin
              nxt_zpp = 1'b1;
            end
          end
        end
      end
      st_hold: begin
        if (!start && ilk) begin
          release_all = 1'b1;
        end
      end
      default: begin
        nxt_state = st_standby;
      end
    endcase
    if (in_run && !start) begin
      nxt_state = st_standby;
    end
    if (!i_hot_mode || qual_reset) begin
      nxt_warn = 1'b0;
    end
    if (det_fault) begin
      lock_bit[`BLO_ERR_DETECT] = 1'b1;
    end else if (flame_lost) begin
      if (i_hot_mode) begin
        nxt_warn = 1'b1;
      end else begin
        lock_bit[`BLO_ERR_FLAME] = 1'b1;
      end
    end
    if (vlv_fault) begin
      lock_bit[`BLO_ERR_VALVE] = 1'b1;
    end
    if (lock_bit != '0) begin
      nxt_state = st_lockout;
      nxt_err = err_ff | lock_bit;
      nxt_alarm = alarm_ff | (lock_bit & ~(blo_err_t'(!i_alarm_configured) << `BLO_ERR_FALSE));
      nxt_lockout = 1'b1;
      nxt_armed = 1'b0;
      nxt_rst_valid = 1'b0;
      nxt_zsb = 1'b0;
    end
    if (release_all) begin
      nxt_state = st_standby;
      nxt_lockout = 1'b0;
      nxt_alarm = '0;
      nxt_long = 1'b0;
    end
    nxt_st_t = (nxt_state != state_ff || clr_st) ? '0 : tinc(st_t_ff, tick_ff);
    // Outputs follow the next state so valves drop in the same edge as the lockout
    nxt_out = {nxt_state != st_standby || nxt_lockout, nxt_state == st_hold,
               nxt_state inside {st_main_trial, st_run}, valve_on(nxt_state), nxt_state == st_pilot_trial};
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= st_standby;
      st_t_ff <= '0;
      aux_t_ff <= '0;
      det_t_ff <= '0;
      vlv_t_ff <= '0;
      rst_t_ff <= '0;
      err_ff <= '0;
      alarm_ff <= '0;
      lockout_ff <= 1'b0;
      armed_ff <= 1'b0;
      rst_valid_ff <= 1'b0;
      long_ff <= 1'b0;
      warn_ff <= 1'b0;
      zsb_ff <= 1'b0;
      zpp_ff <= 1'b0;
      out_ff <= '0;
      stale_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      st_t_ff <= nxt_st_t;
      aux_t_ff <= nxt_aux_t;
      det_t_ff <= nxt_det_t;
      vlv_t_ff <= nxt_vlv_t;
      rst_t_ff <= nxt_rst_t;
      err_ff <= nxt_err;
      alarm_ff <= nxt_alarm;
      lockout_ff <= nxt_lockout;
      armed_ff <= nxt_armed;
      rst_valid_ff <= nxt_rst_valid;
      long_ff <= nxt_long;
      warn_ff <= nxt_warn;
      zsb_ff <= nxt_zsb;
      zpp_ff <= nxt_zpp;
      out_ff <= nxt_out;
      stale_ff <= nxt_stale;
    end
  end

  assign {o_monitor_output, o_led_blink, o_main_valve_output, o_pilot_valve_output, o_igniter_output} = out_ff;
  assign o_lockout_alarm_output = lockout_ff;
  assign o_ignition_failure_alarm = alarm_ff[`BLO_ERR_IGN];
  assign o_flame_failure_alarm = alarm_ff[`BLO_ERR_FLAME];
  assign o_false_flame_alarm = alarm_ff[`BLO_ERR_FALSE];
  assign o_detect_error_alarm = alarm_ff[`BLO_ERR_DETECT];
  assign o_valve_error_alarm = alarm_ff[`BLO_ERR_VALVE];
  assign o_hot_mode_flame_loss_warning = warn_ff;
  assign o_error_display = lockout_ff && state_ff == st_lockout;
  assign o_zone_standby = zsb_ff;
  assign o_zone_prepurge_req = zpp_ff;

  // Press already held when lockout began; tracked apart from the qualifier it checks
  assign nxt_stale = (stale_ff && lockout_ff && !c_rise[`BLO_C_RST]) || (!lockout_ff && nxt_lockout && rst_lvl);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_stale_release;
    stale_ff && state_ff == st_lockout && c_fall[`BLO_C_RST] && !link_cancel;
  endsequence
  a_stale_reset: assert property (s_stale_release |=> lockout_ff)
    else $error("Reset held over lockout entry cancelled it");
  a_ign_outputs: assert property ($rose(o_ignition_failure_alarm) |->
    o_lockout_alarm_output && !o_pilot_valve_output && !o_main_valve_output && !o_igniter_output)
    else $error("Ignition lockout left a valve or alarm wrong");
  a_ign_timeout: assert property (state_ff == st_pilot_trial && st_t_ff >= PILOT_T && !flame |=>
    state_ff == st_lockout && err_ff[`BLO_ERR_IGN]) else $error("Pilot trial without flame not locked");
  a_flame_loss: assert property (state_ff == st_run && !flame && !i_hot_mode |=>
    state_ff == st_lockout ##1 !o_pilot_valve_output && !o_main_valve_output)
    else $error("Flame loss did not lock out");
  a_hot_warn: assert property (state_ff == st_run && !flame && i_hot_mode && start && !det_fault && !vlv_fault
    |=> state_ff == st_run && o_hot_mode_flame_loss_warning) else $error("Hot mode flame loss not warned");
  a_warn_clear: assert property (!i_hot_mode |=> !o_hot_mode_flame_loss_warning)
    else $error("Warning held after hot mode exit");
  a_standby_quiet: assert property (state_ff == st_standby |=> state_ff inside {st_standby, st_check})
    else $error("Standby left to a fault");
  a_false_limit: assert property (state_ff == st_false && flame && start && st_t_ff >= FALSE_T |=>
    state_ff == st_lockout && o_false_flame_alarm == $past(i_alarm_configured))
    else $error("False flame limit not enforced");
  a_long_hold: assert property (state_ff == st_lockout && c_fall[`BLO_C_RST] && long_ff &&
    rst_t_ff < RESET_LONG_T && !link_cancel |=> err_ff == $past(err_ff))
    else $error("Short reset accepted in long hold");
  a_one_clear: assert property (state_ff == st_lockout && cancel |=>
    $countones(err_ff) + 1 == $countones($past(err_ff))) else $error("Reset cleared other than one error");
  a_alarm_release: assert property ($fell(o_lockout_alarm_output) |-> $past(!start && ilk))
    else $error("Lockout alarm cleared with start on");
  a_hold_blink: assert property (state_ff == st_hold && start |=> o_led_blink && o_lockout_alarm_output)
    else $error("Post-reset hold lost blink or alarm");
endmodule

//--- tb/blo_field_model.sv
module blo_field_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_igniter_output,
  input wire logic i_pilot_valve_output,
  input wire logic i_main_valve_output,
  input wire logic i_ignite_ok,
  input wire logic i_flame_kill,
  output logic o_flame_sense,
  output logic o_main_flame_sense,
  output logic o_shutter_closed,
  output logic [3:0] o_closed_confirm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lit_ff;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lit_ff <= 1'b0;
      o_closed_confirm <= 4'hF;
    end else begin
      // Flame needs pilot gas; it catches only while the igniter sparks
      if (!i_pilot_valve_output) begin
        lit_ff <= 1'b0;
      end else if (i_igniter_output && i_ignite_ok) begin
        lit_ff <= 1'b1;
      end
      // Switch reads closed whenever its valve is not driven
      o_closed_confirm <= {~i_main_valve_output, ~i_main_valve_output, ~i_pilot_valve_output,
                           ~i_pilot_valve_output};
    end
  end
  // Kill hides the flame from the sensor without putting it out, so it can come back
  assign o_flame_sense = lit_ff & ~i_flame_kill;
  assign o_main_flame_sense = lit_ff & i_main_valve_output & ~i_flame_kill;
  assign o_shutter_closed = 1'b0;
endmodule

//--- tb/tb_blo_sequencer.sv
module tb_blo_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import blo_pkg::*;
  localparam int HOLD = 480;
  localparam logic [6:0] LOCK = 7'h40, IGN = 7'h20, FLM = 7'h10, WARN = 7'h01;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_reset_contact = 1'b0, i_start = 1'b0;
  logic i_interlock_ok = 1'b1, i_hot_mode = 1'b0, i_alarm_configured = 1'b1;
  logic i_link_connected = 1'b0, i_link_reset = 1'b0, i_link_legacy = 1'b0, i_zone_combusting = 1'b0;
  blo_zone_t i_zone_locked_count = 8'h00, i_zone_threshold = 8'h01;
  logic ignite_ok = 1'b1, flame_kill = 1'b0, flame, main_flame, shutter;
  logic [3:0] confirm;
  logic o_igniter_output, o_pilot_valve_output, o_main_valve_output, o_lockout_alarm_output;
  logic o_ignition_failure_alarm, o_flame_failure_alarm, o_false_flame_alarm, o_detect_error_alarm;
  logic o_valve_error_alarm, o_hot_mode_flame_loss_warning;
  logic [6:0] alarms;
  logic led, mon, err_disp, zsb, zpp;
  logic [6:0] expq[$];
  int miscompares = 0, n_tests = 0, cycles = 0;
  assign alarms = {o_lockout_alarm_output, o_ignition_failure_alarm, o_flame_failure_alarm,
                   o_false_flame_alarm, o_detect_error_alarm, o_valve_error_alarm, o_hot_mode_flame_loss_warning};
  blo_sequencer #(.TICK_CYCLES(20), .CTL_DB_CYCLES(4), .SNS_DB_CYCLES(2)) i_blo_sequencer (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_contact(i_reset_contact), .i_start(i_start),
    .i_interlock_ok(i_interlock_ok), .i_flame_sense(flame), .i_main_flame_sense(main_flame),
    .i_shutter_closed(shutter), .i_pilot_closed_confirm_a(confirm[0]), .i_pilot_closed_confirm_b(confirm[1]),
    .i_main_closed_confirm_a(confirm[2]), .i_main_closed_confirm_b(confirm[3]), .i_hot_mode(i_hot_mode),
    .i_alarm_configured(i_alarm_configured), .i_link_connected(i_link_connected), .i_link_reset(i_link_reset),
    .i_link_legacy(i_link_legacy), .i_zone_locked_count(i_zone_locked_count), .i_zone_threshold(i_zone_threshold),
    .i_zone_combusting(i_zone_combusting), .o_igniter_output(o_igniter_output),
    .o_pilot_valve_output(o_pilot_valve_output), .o_main_valve_output(o_main_valve_output),
    .o_lockout_alarm_output(o_lockout_alarm_output), .o_ignition_failure_alarm(o_ignition_failure_alarm),
    .o_flame_failure_alarm(o_flame_failure_alarm), .o_false_flame_alarm(o_false_flame_alarm),
    .o_detect_error_alarm(o_detect_error_alarm), .o_valve_error_alarm(o_valve_error_alarm),
    .o_hot_mode_flame_loss_warning(o_hot_mode_flame_loss_warning), .o_led_blink(led), .o_monitor_output(mon),
    .o_error_display(err_disp), .o_zone_standby(zsb), .o_zone_prepurge_req(zpp)
  );
  blo_field_model i_blo_field_model (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_igniter_output(o_igniter_output),
    .i_pilot_valve_output(o_pilot_valve_output), .i_main_valve_output(o_main_valve_output),
    .i_ignite_ok(ignite_ok), .i_flame_kill(flame_kill), .o_flame_sense(flame),
    .o_main_flame_sense(main_flame), .o_shutter_closed(shutter), .o_closed_confirm(confirm)
  );
  always #25 i_clk_sys = ~i_clk_sys;
  task automatic complete_run;
    if (expq.size() != 0) miscompares++;
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_lvl(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic wait_until(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    chk_lvl(s, 1'b1);
  endtask
  task automatic start_burner;
    i_start = 1'b0;
    cyc(420);
    i_start = 1'b1;
  endtask
  task automatic do_reset(input int n);
    i_reset_contact = 1'b1;
    cyc(n);
    i_reset_contact = 1'b0;
    cyc(40);
  endtask
  // Unexpected alarm changes find an empty queue and compare against the old value
  initial begin
    logic [6:0] prev;
    wait (i_rst === 1'b0);
    @(negedge i_clk_sys);
    prev = alarms;
    forever begin
      @(negedge i_clk_sys);
      if (alarms !== prev) begin
        if (expq.size() == 0) chk_vec(alarms, prev);
        else chk_vec(alarms, expq.pop_front());
        prev = alarms;
      end
    end
  end
  initial begin
    void'($urandom(86));
    i_zone_threshold = 8'($urandom_range(1, 8));
    i_zone_locked_count = 8'($urandom_range(0, 8));
    i_zone_combusting = 1'($urandom);
    i_alarm_configured = 1'($urandom);
    repeat (16) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_rst = 1'b0;
    cyc(20);
    i_hot_mode = 1'b1;
    start_burner();
    wait_until(o_main_valve_output, 6000);
    cyc(1100);
    expq.push_back(WARN);
    flame_kill = 1'b1;
    cyc(100);
    chk_lvl(o_main_valve_output, 1'b1);
    flame_kill = 1'b0;
    cyc(20);
    expq.push_back(7'h00);
    i_hot_mode = 1'b0;
    cyc(20);
    expq.push_back(LOCK | FLM);
    flame_kill = 1'b1;
    cyc(60);
    chk_lvl(o_pilot_valve_output | o_main_valve_output, 1'b0);
    flame_kill = 1'b0;
    cyc(100);
    do_reset(200);
    chk_lvl(o_lockout_alarm_output, 1'b1);
    chk_lvl(err_disp, 1'b1);
    // Cancel with start still on: post-reset hold and zone reaction
    i_link_connected = 1'b1;
    i_link_legacy = 1'b1;
    i_link_reset = 1'b1;
    cyc(1);
    i_link_reset = 1'b0;
    chk_lvl(zpp, i_zone_locked_count < i_zone_threshold && !i_zone_combusting);
    cyc(20);
    chk_lvl(led & mon & ~err_disp, 1'b1);
    chk_lvl(zsb, i_zone_locked_count >= i_zone_threshold);
    chk_lvl(o_lockout_alarm_output, 1'b1);
    expq.push_back(7'h00);
    i_start = 1'b0;
    cyc(40);
    chk_lvl(led | zsb | mon, 1'b0);
    i_link_connected = 1'b0;
    ignite_ok = 1'b0;
    expq.push_back(LOCK | IGN);
    start_burner();
    // Contact closed before the error must not count as a reset
    i_reset_contact = 1'b1;
    wait_until(o_lockout_alarm_output, 4000);
    chk_lvl(o_pilot_valve_output | o_igniter_output, 1'b0);
    i_start = 1'b0;
    cyc(HOLD);
    i_reset_contact = 1'b0;
    cyc(40);
    chk_lvl(o_lockout_alarm_output, 1'b1);
    expq.push_back(7'h00);
    do_reset(HOLD + $urandom_range(0, 40));
    ignite_ok = 1'b1;
    chk_lvl(o_lockout_alarm_output, 1'b0);
    complete_run();
  end
endmodule
